// file: hdl/sdc_defs.svh
// Constants of the servo drive contact I/O block: offsets, fields, reset values, timing.
// Assumes a 100 MHz mclk and 32-bit Avalon-MM word registers at byte addresses.
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

// Timing
`define SDC_CLK_NS      10
`define SDC_MS_NS       1000000
`define SDC_MS_CYCLES   (`SDC_MS_NS / `SDC_CLK_NS)
`define SDC_DB_MS       2'h2

// Contact input positions
`define SDC_NIN         8
`define SDC_IN_DIR      0
`define SDC_IN_LOOP     1
`define SDC_IN_STOP     2
`define SDC_IN_CCW      3
`define SDC_IN_CW       4
`define SDC_IN_TSRC     5
`define SDC_IN_CLR      6
`define SDC_IN_HALT     7
`define SDC_PIN_IDLE    8'hff

// Fault source positions
`define SDC_F_OC        0
`define SDC_F_OV        1
`define SDC_F_OL        2
`define SDC_F_PWR       3
`define SDC_F_ENC       4
`define SDC_F_OTHER     5

// Register byte offsets
`define SDC_OFS_CTRL    6'h00
`define SDC_OFS_SPEED_REACHED_OUT   6'h04
`define SDC_OFS_POSITION_REACHED_OUT   6'h08
`define SDC_OFS_BRKSPD  6'h0c
`define SDC_OFS_BRKTIME 6'h10
`define SDC_OFS_TRQDIG  6'h14
`define SDC_OFS_FAULT   6'h18
`define SDC_OFS_STATUS  6'h1c

// Control fields
`define SDC_CTRL_MODE   0
`define SDC_CTRL_STOPSEL 2
`define SDC_CTRL_HALTPOL 3

// Reset values
`define SDC_MODE_RST    2'h1
`define SDC_SPEED_REACHED_OUT_RST   16'h000a
`define SDC_POSITION_REACHED_OUT_RST   16'h0010
`define SDC_BRKSPD_RST  16'h0032
`define SDC_BRKTIME_RST 16'h0032
`define SDC_TRQDIG_RST  16'h7fff
`define SDC_ZERO_SPD    17'h0000a

`endif

// file: hdl/sdc_pkg.sv
// Types of the servo drive contact I/O block: modes, halt states, state records.
// Assumes sdc_defs.svh is on the include path.
`include "sdc_defs.svh"
package sdc_pkg;
	typedef enum logic [1:0] {
		SDC_MODE_TORQUE = 2'b00,
		SDC_MODE_SPEED  = 2'b01,
		SDC_MODE_POS    = 2'b10
	} sdc_mode_t;
	typedef enum logic [1:0] {
		SDC_HALT_RUN   = 2'b00,
		SDC_HALT_DECEL = 2'b01,
		SDC_HALT_COAST = 2'b10
	} sdc_halt_t;
	typedef struct packed {
		logic [`SDC_NIN-1:0]       s1;
		logic [`SDC_NIN-1:0]       s2;
		logic [`SDC_NIN-1:0]       stable;
		logic [`SDC_NIN-1:0][1:0]  cnt;
	} sdc_db_t;
	typedef struct packed {
		logic                ack;
		logic [31:0]         rdata;
		sdc_mode_t           mode;
		logic                stop_sel;
		logic                halt_pol;
		logic [15:0]         speed_reached_out;
		logic [15:0]         position_reached_out;
		logic [15:0]         brkspd;
		logic [15:0]         brktime;
		logic [15:0]         trqdig;
		logic [5:0]          faults;
		sdc_halt_t           halt;
		logic [16:0]         tick_cnt;
		logic                tick;
		logic [15:0]         brk_cnt;
		logic                clr_d;
		logic                powered;
		logic signed [15:0]  speed_cmd;
		logic [15:0]         torque_cap;
		logic                p_only;
		logic                err_clear;
		logic                decel;
		logic                coast;
		logic                run;
		logic                brake;
		logic                reached;
		logic                stopped;
		logic                capped;
		logic                ready;
		logic                alarm;
		logic [2:0]          code;
	} sdc_core_t;
endpackage

// file: hdl/sdc_contact_if.sv
// Carrier between the core and the contact filter: raw pins in, ON levels out.
// Assumes both ends run on mclk; ce and tick come from the core.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defs.svh"
interface sdc_contact_if;
	logic                ce;
	logic                tick;
	logic [`SDC_NIN-1:0] raw;
	logic [`SDC_NIN-1:0] on;
	modport filt (input ce, input tick, input raw, output on);
	modport core (output ce, output tick, output raw, input on);
endinterface
`default_nettype wire

// file: hdl/sdc_debounce.sv
// Contact filter: two-flop synchroniser and millisecond debounce per contact.
// Assumes a one-cycle tick every millisecond and synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defs.svh"
module sdc_debounce (
	input  wire logic  mclk,    // System clock
	input  wire logic  rstn,    // Synchronous reset, active low
	sdc_contact_if.filt cif     // Raw contacts in, ON levels out
);
	import sdc_pkg::*;
	sdc_db_t s;
	sdc_db_t next_s;

	// Pin high is OFF, so the idle value is all ones
	assign cif.on = ~s.stable;

	// Level must hold for DB_MS ticks before it is accepted
	always_comb begin
		next_s = s;
		next_s.s1 = cif.raw;
		next_s.s2 = s.s1;
		for (int i = 0; i < `SDC_NIN; i++) begin
			if (s.s2[i] == s.stable[i]) begin
				next_s.cnt[i] = 2'h0;
			end else if (cif.tick) begin
				if (s.cnt[i] == `SDC_DB_MS - 2'h1) begin
					next_s.stable[i] = s.s2[i];
					next_s.cnt[i]    = 2'h0;
				end else begin
					next_s.cnt[i] = s.cnt[i] + 2'h1;
				end
			end
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s <= '{s1: `SDC_PIN_IDLE, s2: `SDC_PIN_IDLE, stable: `SDC_PIN_IDLE, default: '0};
		end else if (cif.ce) begin
			s <= next_s;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_db_tick;
		$changed(s.stable) |-> $past(cif.ce && cif.tick);
	endproperty
	a_db_tick: assert property (p_db_tick) else $error("contact level changed off a tick");
endmodule // sdc_debounce
`default_nettype wire

// file: hdl/sdc_contact_io.sv
// Servo drive contact I/O core: contact inputs, status outputs, halt, brake, registers.
// Assumes contact pins are asynchronous, drive core signals are registered, Avalon-MM master.
`timescale 1ns/1ns
`default_nettype none
`include "sdc_defs.svh"
module sdc_contact_io #(
	parameter int unsigned MS_TICK_CYCLES = `SDC_MS_CYCLES // Cycles per millisecond
) (
	input  wire logic                mclk,                   // System clock, 100 MHz
	input  wire logic                rstn,                   // Synchronous reset, active low
	input  wire logic                ce,                     // Clock enable, freezes state
	input  wire logic [5:0]          avs_address,            // Byte address
	input  wire logic                avs_read,               // Read request
	input  wire logic                avs_write,              // Write request
	input  wire logic [31:0]         avs_writedata,          // Write data
	input  wire logic [3:0]          avs_byteenable,         // Byte lanes
	output logic [31:0]              avs_readdata,           // Read data
	output logic                     avs_waitrequest,        // Stall
	input  wire logic                dir_select_in_n,        // Direction contact
	input  wire logic                speed_loop_type_in_n,   // Loop-type contact
	input  wire logic                stop_start_in_n,        // Stop/start contact
	input  wire logic                ccw_travel_permit_in_n, // CCW permit contact
	input  wire logic                cw_travel_permit_in_n,  // CW permit contact
	input  wire logic                torque_cap_source_in_n, // Torque source contact
	input  wire logic                fault_clear_in_n,       // Fault clear contact
	input  wire logic                emergency_halt_in,      // Halt contact, raw level
	input  wire logic                power_good_in,          // Supply good
	input  wire logic [5:0]          fault_src_in,           // Detected faults
	input  wire logic signed [15:0]  speed_cmd_in,           // Commanded speed
	input  wire logic signed [15:0]  speed_fb_in,            // Actual speed
	input  wire logic signed [15:0]  pos_err_in,             // Position error
	input  wire logic [15:0]         torque_req_in,          // Torque demand
	input  wire logic [15:0]         analog_torque_cap_in,   // Analog torque cap
	output logic signed [15:0]       speed_cmd_out,          // Effective speed command
	output logic [15:0]              torque_cap_out,         // Applied torque cap
	output logic                     p_only_out,             // Proportional only
	output logic                     err_clear_out,          // Clear error count
	output logic                     decel_out,              // Rapid deceleration
	output logic                     coast_out,              // Free run
	output logic                     run_enable_out,         // Motion permitted
	output logic                     brake_out_n,            // Brake contact
	output logic                     ready_out_n,            // Ready contact
	output logic                     reached_out_n,          // Completion contact
	output logic                     alarm_ok_out_n,         // Alarm contact
	output logic                     fault_code_bit0_n,      // Fault code bit 0
	output logic                     fault_code_bit1_n,      // Fault code bit 1
	output logic                     fault_code_bit2_n,      // Fault code bit 2
	output logic                     motor_stopped_out_n,    // Zero speed contact
	output logic                     torque_capped_out_n     // Torque status contact
);
	import sdc_pkg::*;

	sdc_core_t     s;
	sdc_core_t     next_s;
	sdc_contact_if cif ();

	// Magnitude of a widened signed value
	function automatic logic [16:0] sdc_abs(input logic signed [16:0] v);
		sdc_abs = v[16] ? 17'(-v) : v;
	endfunction

	// Negation that does not wrap at the most negative value
	function automatic logic signed [15:0] sdc_neg(input logic signed [15:0] v);
		sdc_neg = (v == 16'sh8000) ? 16'sh7fff : 16'(-v);
	endfunction

	// Byte-lane merge of a write into a 16-bit field
	function automatic logic [15:0] sdc_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		sdc_merge[7:0]  = be[0] ? wd[7:0] : old[7:0];
		sdc_merge[15:8] = be[1] ? wd[15:8] : old[15:8];
	endfunction

	// Halt has priority, then faults in fixed order
	function automatic logic [2:0] sdc_code(input logic halted, input logic [5:0] f);
		if (halted)                 sdc_code = 3'h7;
		else if (f[`SDC_F_OC])      sdc_code = 3'h6;
		else if (f[`SDC_F_OV])      sdc_code = 3'h5;
		else if (f[`SDC_F_OL])      sdc_code = 3'h4;
		else if (f[`SDC_F_PWR])     sdc_code = 3'h3;
		else if (f[`SDC_F_ENC])     sdc_code = 3'h2;
		else if (f[`SDC_F_OTHER])   sdc_code = 3'h1;
		else                        sdc_code = 3'h0;
	endfunction

	// Contact filter
	assign cif.ce   = ce;
	assign cif.tick = s.tick;
	assign cif.raw  = {emergency_halt_in, fault_clear_in_n, torque_cap_source_in_n,
		cw_travel_permit_in_n, ccw_travel_permit_in_n, stop_start_in_n,
		speed_loop_type_in_n, dir_select_in_n};
	sdc_debounce u_debounce (
		.mclk (mclk),
		.rstn (rstn),
		.cif  (cif)
	);

	// Bus handshake: one stall cycle, answer held while frozen
	assign avs_waitrequest = (avs_read | avs_write) & ~(s.ack & ce);
	assign avs_readdata    = s.rdata;

	// Contacts drive low for ON
	assign speed_cmd_out       = s.speed_cmd;
	assign torque_cap_out      = s.torque_cap;
	assign p_only_out          = s.p_only;
	assign err_clear_out       = s.err_clear;
	assign decel_out           = s.decel;
	assign coast_out           = s.coast;
	assign run_enable_out      = s.run;
	assign brake_out_n         = ~s.brake;
	assign ready_out_n         = ~s.ready;
	assign reached_out_n       = ~s.reached;
	assign alarm_ok_out_n      = s.alarm;
	assign fault_code_bit0_n   = ~s.code[0];
	assign fault_code_bit1_n   = ~s.code[1];
	assign fault_code_bit2_n   = ~s.code[2];
	assign motor_stopped_out_n = ~s.stopped;
	assign torque_capped_out_n = ~s.capped;

	logic                on_halt;
	logic                halted;
	logic                clr_rise;
	logic                alarm_any;
	logic signed [15:0]  cmd;
	logic                start_ok;
	logic [16:0]         fb_mag;

	// Next-state logic
	always_comb begin
		next_s    = s;
		on_halt   = cif.on[`SDC_IN_HALT] ^ s.halt_pol;
		halted    = (s.halt != SDC_HALT_RUN);
		clr_rise  = cif.on[`SDC_IN_CLR] & ~s.clr_d & ~halted;
		fb_mag    = sdc_abs(17'(speed_fb_in));
		cmd       = speed_cmd_in;
		start_ok  = 1'b1;

		// Millisecond tick for debounce and brake timing
		next_s.tick = 1'b0;
		if (s.tick_cnt == 17'(MS_TICK_CYCLES - 1)) begin
			next_s.tick_cnt = 17'h00000;
			next_s.tick     = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 17'h00001;
		end

		// Bus: read data latched on the stall cycle, write applied on the accept cycle
		next_s.ack = (avs_read | avs_write) & ~s.ack;
		if (avs_read & ~s.ack) begin
			unique case (avs_address)
				`SDC_OFS_CTRL:    next_s.rdata = {28'h0000000, s.halt_pol, s.stop_sel, s.mode};
				`SDC_OFS_SPEED_REACHED_OUT:   next_s.rdata = {16'h0000, s.speed_reached_out};
				`SDC_OFS_POSITION_REACHED_OUT:   next_s.rdata = {16'h0000, s.position_reached_out};
				`SDC_OFS_BRKSPD:  next_s.rdata = {16'h0000, s.brkspd};
				`SDC_OFS_BRKTIME: next_s.rdata = {16'h0000, s.brktime};
				`SDC_OFS_TRQDIG:  next_s.rdata = {16'h0000, s.trqdig};
				`SDC_OFS_FAULT:   next_s.rdata = {26'h0000000, s.faults};
				`SDC_OFS_STATUS:  next_s.rdata = {8'h00, cif.on, 5'h00, s.halt, s.brake,
					s.capped, s.stopped, s.code, s.alarm, s.reached, s.ready};
				default:          next_s.rdata = 32'h00000000;
			endcase
		end
		if (avs_write & s.ack) begin
			unique case (avs_address)
				`SDC_OFS_CTRL: begin
					if (avs_byteenable[0]) begin
						next_s.mode     = sdc_mode_t'(avs_writedata[`SDC_CTRL_MODE +: 2]);
						next_s.stop_sel = avs_writedata[`SDC_CTRL_STOPSEL];
						next_s.halt_pol = avs_writedata[`SDC_CTRL_HALTPOL];
					end
				end
				`SDC_OFS_SPEED_REACHED_OUT:   next_s.speed_reached_out   = sdc_merge(s.speed_reached_out, avs_writedata, avs_byteenable);
				`SDC_OFS_POSITION_REACHED_OUT:   next_s.position_reached_out   = sdc_merge(s.position_reached_out, avs_writedata, avs_byteenable);
				`SDC_OFS_BRKSPD:  next_s.brkspd  = sdc_merge(s.brkspd, avs_writedata, avs_byteenable);
				`SDC_OFS_BRKTIME: next_s.brktime = sdc_merge(s.brktime, avs_writedata, avs_byteenable);
				`SDC_OFS_TRQDIG:  next_s.trqdig  = sdc_merge(s.trqdig, avs_writedata, avs_byteenable);
				default: ;
			endcase
		end

		// Latched faults; a new fault beats a clear in the same cycle
		next_s.clr_d  = cif.on[`SDC_IN_CLR];
		next_s.faults = (s.faults & ~{6{clr_rise}}) | fault_src_in;
		alarm_any     = (|s.faults) | halted;
		next_s.alarm  = alarm_any;
		next_s.code   = sdc_code(halted, s.faults);

		// Emergency halt: hard stop, then coast until released
		unique case (s.halt)
			SDC_HALT_RUN:   if (on_halt) next_s.halt = SDC_HALT_DECEL;
			SDC_HALT_DECEL: if (fb_mag <= `SDC_ZERO_SPD) next_s.halt = SDC_HALT_COAST;
			SDC_HALT_COAST: if (!on_halt) next_s.halt = SDC_HALT_RUN;
			default:        next_s.halt = SDC_HALT_RUN;
		endcase
		next_s.decel = (s.halt == SDC_HALT_DECEL);
		next_s.coast = (s.halt == SDC_HALT_COAST);

		// Speed command path: direction, stop/start, travel permits
		if (s.mode == SDC_MODE_SPEED && cif.on[`SDC_IN_DIR]) begin
			cmd = sdc_neg(speed_cmd_in);
		end
		if (s.stop_sel) begin
			start_ok = cif.on[`SDC_IN_STOP];
		end else if (cif.on[`SDC_IN_STOP]) begin
			cmd = 16'sh0000;
		end
		if ((cmd > 16'sh0000 && !cif.on[`SDC_IN_CCW]) ||
			(cmd < 16'sh0000 && !cif.on[`SDC_IN_CW])) begin
			cmd = 16'sh0000;
		end
		next_s.run = start_ok & ~alarm_any & power_good_in;
		// Speed command, loop-type and clear inputs are ignored during a halt; the torque source contact still applies
		next_s.speed_cmd  = next_s.run ? cmd : 16'sh0000;
		next_s.p_only     = cif.on[`SDC_IN_LOOP] & ~halted;
		next_s.torque_cap = cif.on[`SDC_IN_TSRC] ? analog_torque_cap_in : s.trqdig;
		next_s.err_clear  = (s.mode == SDC_MODE_POS) & clr_rise;

		// Status contacts
		next_s.stopped = (fb_mag <= `SDC_ZERO_SPD);
		if (s.mode == SDC_MODE_SPEED) begin
			next_s.reached = sdc_abs(17'(cmd) - 17'(speed_fb_in)) <= {1'b0, s.speed_reached_out};
		end else if (s.mode == SDC_MODE_POS) begin
			next_s.reached = sdc_abs(17'(pos_err_in)) <= {1'b0, s.position_reached_out};
		end else begin
			next_s.reached = 1'b0;
		end
		next_s.capped = (s.mode == SDC_MODE_TORQUE) | (torque_req_in > s.torque_cap);
		next_s.powered = 1'b1;
		next_s.ready   = s.powered & power_good_in & ~alarm_any;

		// Brake holds off until speed is low or the hold time is spent
		if (next_s.run) begin
			next_s.brake   = 1'b1;
			next_s.brk_cnt = 16'h0000;
		end else if (s.brake) begin
			if (s.tick && s.brk_cnt != 16'hffff) begin
				next_s.brk_cnt = s.brk_cnt + 16'h0001;
			end
			if (fb_mag <= {1'b0, s.brkspd} || s.brk_cnt >= s.brktime) begin
				next_s.brake = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s <= '{mode: sdc_mode_t'(`SDC_MODE_RST), halt: SDC_HALT_RUN,
				speed_reached_out: `SDC_SPEED_REACHED_OUT_RST, position_reached_out: `SDC_POSITION_REACHED_OUT_RST, brkspd: `SDC_BRKSPD_RST,
				brktime: `SDC_BRKTIME_RST, trqdig: `SDC_TRQDIG_RST, default: '0};
		end else if (ce) begin
			s <= next_s;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_halt_zero;
		(ce && s.halt != SDC_HALT_RUN) |=> (speed_cmd_out == 16'sh0000 && !run_enable_out);
	endproperty
	a_halt_zero: assert property (p_halt_zero) else $error("command not zero in halt");

	property p_halt_code;
		(ce && s.halt != SDC_HALT_RUN) |=> (!fault_code_bit0_n && !fault_code_bit1_n
			&& !fault_code_bit2_n && alarm_ok_out_n);
	endproperty
	a_halt_code: assert property (p_halt_code) else $error("halt code not shown");

	property p_alarm_pin;
		(ce && s.faults != 6'h00) |=> alarm_ok_out_n;
	endproperty
	a_alarm_pin: assert property (p_alarm_pin) else $error("alarm contact still ON");

	property p_loop;
		(ce && s.halt == SDC_HALT_RUN) |=> (p_only_out == $past(cif.on[`SDC_IN_LOOP]));
	endproperty
	a_loop: assert property (p_loop) else $error("loop type not followed");

	property p_tsrc;
		(ce && cif.on[`SDC_IN_TSRC]) |=> (torque_cap_out == $past(analog_torque_cap_in));
	endproperty
	a_tsrc: assert property (p_tsrc) else $error("analog torque cap not applied");

	property p_ccw;
		(ce && !cif.on[`SDC_IN_CCW]) |=> (speed_cmd_out <= 16'sh0000);
	endproperty
	a_ccw: assert property (p_ccw) else $error("motion toward blocked side");

	property p_clear;
		(ce && s.mode == SDC_MODE_POS && s.halt == SDC_HALT_RUN && cif.on[`SDC_IN_CLR]
			&& !s.clr_d) |=> err_clear_out;
	endproperty
	a_clear: assert property (p_clear) else $error("error count not cleared");

	// Run and brake are set on one edge, so the brake is ON whenever run is
	property p_brake;
		(ce && run_enable_out) |-> !brake_out_n;
	endproperty
	a_brake: assert property (p_brake) else $error("brake off while running");

	property p_ready;
		(ce && !power_good_in) |=> ready_out_n;
	endproperty
	a_ready: assert property (p_ready) else $error("ready without power good");

	property p_cw;
		(ce && !cif.on[`SDC_IN_CW]) |=> (speed_cmd_out >= 16'sh0000);
	endproperty
	a_cw: assert property (p_cw) else $error("clockwise motion while blocked");

	property p_tdig;
		(ce && !cif.on[`SDC_IN_TSRC]) |=> (torque_cap_out == $past(s.trqdig));
	endproperty
	a_tdig: assert property (p_tdig) else $error("digital torque cap not applied");

	property p_stopped;
		(ce && speed_fb_in == 16'sh0000) |=> !motor_stopped_out_n;
	endproperty
	a_stopped: assert property (p_stopped) else $error("standstill not shown");

	property p_decel;
		(ce && s.halt == SDC_HALT_DECEL) |=> (decel_out && !coast_out);
	endproperty
	a_decel: assert property (p_decel) else $error("rapid stop not shown");

	property p_coast;
		(ce && s.halt == SDC_HALT_COAST) |=> (coast_out && !decel_out);
	endproperty
	a_coast: assert property (p_coast) else $error("free run not shown");

	// One clear per contact edge, never a level
	property p_clear_once;
		(ce && err_clear_out) |=> !err_clear_out;
	endproperty
	a_clear_once: assert property (p_clear_once) else $error("error clear held");

	property p_tmode;
		(ce && s.mode == SDC_MODE_TORQUE) |=> !torque_capped_out_n;
	endproperty
	a_tmode: assert property (p_tmode) else $error("torque mode not shown");

	property p_bus;
		(ce && (avs_read || avs_write) && !s.ack) |-> avs_waitrequest ##1 (!ce || !avs_waitrequest);
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer not after one stall");
endmodule // sdc_contact_io
`default_nettype wire

// file: dv/sdc_plc_model.sv
// Upper controller model: open-collector contacts toward the drive.
// Assumes ON wishes from the bench; a released contact is pulled up.
`timescale 1ns/1ns
`default_nettype none
module sdc_plc_model (
	input  wire logic       mclk,  // Drive clock
	input  wire logic [7:0] on,    // Wanted ON levels
	output logic      [7:0] pin_n  // Contact pins, low = ON
);
	// Released contacts float to +24 V, so OFF reads high; reset covers the first edge
	always @(posedge mclk) begin
		pin_n <= ~on;
	end
endmodule // sdc_plc_model
`default_nettype wire

// file: dv/sdc_contact_io_tb_top.sv
// Bench for the contact I/O core: registers, contacts, halt, fault codes.
// Assumes core, package, interface, filter and controller model compiled first.
`timescale 1ns/1ns
`default_nettype none
module sdc_contact_io_tb_top;
	logic               mclk = 0, rstn = 0, rd = 0, wr = 0, wreq, wreq_s, ce = 1, pg = 1;
	logic        [5:0]  adr = 0, flt = 0;
	logic        [31:0] wdat = 0, rdat, rdat_s, rnd = 32'h000185b8;
	logic        [7:0]  on = 8'h18, pin_n;
	logic signed [15:0] cmd = 0, perr = 0, scmd;
	logic        [15:0] acap = 0, tcap;
	logic               p_only, brake_n, ready_n, reach_n, alarm_n, stop_n, cap_n, coast;
	logic        [2:0]  code_n;
	int                 n_fail = 0, n_checks = 0;
	logic        [31:0] q_bus[$], q_pin[$];
	event               probe;
	string              nm[4] = '{"speed_cmd", "torque_cap", "alarm_code", "status"};
	// Code ON patterns {b2,b1,b0}: overcurrent, overvolt, overload, power, encoder, other
	logic        [2:0]  tbl[6] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};

	always #5 mclk = ~mclk;

	sdc_contact_io #(.MS_TICK_CYCLES(10)) sdc_contact_io_inst (
		.mclk(mclk), .rstn(rstn), .ce(ce), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'h3),
		.avs_readdata(rdat), .avs_waitrequest(wreq), .dir_select_in_n(pin_n[0]),
		.speed_loop_type_in_n(pin_n[1]), .stop_start_in_n(pin_n[2]),
		.ccw_travel_permit_in_n(pin_n[3]), .cw_travel_permit_in_n(pin_n[4]),
		.torque_cap_source_in_n(pin_n[5]), .fault_clear_in_n(pin_n[6]),
		.emergency_halt_in(pin_n[7]), .power_good_in(pg), .fault_src_in(flt),
		.speed_cmd_in(cmd), .speed_fb_in(16'sh0000), .pos_err_in(perr),
		.torque_req_in(16'h0000), .analog_torque_cap_in(acap), .speed_cmd_out(scmd),
		.torque_cap_out(tcap), .p_only_out(p_only), .err_clear_out(), .decel_out(),
		.coast_out(coast), .run_enable_out(), .brake_out_n(brake_n), .ready_out_n(ready_n),
		.reached_out_n(reach_n), .alarm_ok_out_n(alarm_n), .fault_code_bit0_n(code_n[0]),
		.fault_code_bit1_n(code_n[1]), .fault_code_bit2_n(code_n[2]),
		.motor_stopped_out_n(stop_n), .torque_capped_out_n(cap_n));

	sdc_plc_model sdc_plc_model_inst (.mclk(mclk), .on(on), .pin_n(pin_n));

	// Settled copies, taken away from the active edge to dodge races
	always @(negedge mclk) begin
		wreq_s = wreq;
		rdat_s = rdat;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction

	task automatic final_report;
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmp_bus(input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected readdata exp %h seen %h", e, s);
		end
	endtask

	task automatic cmp_pin(input logic [31:0] n);
		logic [23:0] s;
		case (n[25:24])
			2'h0: s = {8'h00, scmd};
			2'h1: s = {8'h00, tcap};
			2'h2: s = {19'h0, coast, alarm_n, code_n};
			default: s = {17'h0, ready_n, alarm_n, stop_n, brake_n, p_only, cap_n, reach_n};
		endcase
		n_checks++;
		if (s !== n[23:0]) begin
			n_fail++;
			$display("unexpected %s exp %h seen %h", nm[n[25:24]], n[23:0], s);
		end
	endtask

	// Read answers pair with the oldest bus note
	always @(posedge mclk) begin
		if (rd && !wreq_s && q_bus.size() > 0)
			cmp_bus(q_bus.pop_front(), rdat_s);
	end

	// Pin notes are compared when the driver raises the probe
	always @(probe) begin
		while (q_pin.size() > 0)
			cmp_pin(q_pin.pop_front());
	end

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic note_pin(input logic [1:0] k, input logic [23:0] v);
		@(negedge mclk);
		q_pin.push_back({6'h00, k, v});
		->probe;
	endtask

	// Request held until waitrequest is seen low at an edge; read d is the expectation
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		if (!w)
			q_bus.push_back(d);
		// No limit of its own: a hang is left to the watchdog
		do
			@(posedge mclk);
		while (wreq_s);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// Contacts need the debounce span before they count
	task automatic set_on(input logic [7:0] v);
		@(posedge mclk);
		on <= v;
		wt(40);
	endtask

	task automatic chk_st(input logic [1:0] m, input logic [15:0] c, p, input logic [6:0] v);
		bus(1'b1, 6'h00, {30'h0, m});
		cmd <= c;
		perr <= p;
		wt(3);
		note_pin(2'h3, {17'h0, v});
	endtask

	// Main sequence
	initial begin
		wt(5);
		rstn <= 1'b1;
		wt(40);
		note_pin(2'h3, 24'h02);
		// Power loss drops ready and run, so the brake falls too
		@(posedge mclk);
		pg <= 1'b0;
		wt(3);
		note_pin(2'h3, 24'h4a);
		@(posedge mclk);
		pg <= 1'b1;
		bus(1'b0, 6'h00, 32'h1);
		bus(1'b0, 6'h04, 32'ha);
		bus(1'b0, 6'h20, 32'h0);
		bus(1'b1, 6'h14, 32'h1234);
		bus(1'b0, 6'h14, 32'h1234);
		rnd = xs(rnd);
		cmd <= {2'b00, rnd[13:1], 1'b1};
		wt(3);
		note_pin(2'h0, {8'h00, cmd});
		// Clock enable low must hold the old command
		@(posedge mclk);
		ce <= 1'b0;
		cmd <= 16'sh0000;
		wt(3);
		note_pin(2'h0, {10'h000, rnd[13:1], 1'b1});
		@(posedge mclk);
		ce <= 1'b1;
		cmd <= {2'b00, rnd[13:1], 1'b1};
		set_on(8'h19);
		note_pin(2'h0, {8'h00, -cmd});
		set_on(8'h09);
		note_pin(2'h0, 24'h0);
		set_on(8'h10);
		note_pin(2'h0, 24'h0);
		set_on(8'h1c);
		note_pin(2'h0, 24'h0);
		set_on(8'h1a);
		note_pin(2'h3, 24'h07);
		@(posedge mclk);
		acap <= rnd[31:16];
		set_on(8'h38);
		note_pin(2'h1, {8'h00, acap});
		set_on(8'h18);
		note_pin(2'h1, 24'h1234);
		chk_st(2'h0, 16'h0000, 16'h0000, 7'h01);
		chk_st(2'h2, 16'h0000, 16'h0010, 7'h02);
		chk_st(2'h2, 16'h0000, 16'h0011, 7'h03);
		chk_st(2'h1, 16'h000a, 16'h0000, 7'h02);
		chk_st(2'h1, 16'h000b, 16'h0000, 7'h03);
		// Position mode, so each clear also pulses the error-count clear
		bus(1'b1, 6'h00, 32'h2);
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			flt <= 6'h01 << i;
			wt(1);
			flt <= 6'h00;
			wt(3);
			note_pin(2'h2, {20'h0, 1'b1, ~tbl[i]});
			set_on(8'h58);
			set_on(8'h18);
			note_pin(2'h2, 24'h7);
		end
		set_on(8'h98);
		note_pin(2'h2, 24'h18);
		set_on(8'h99);
		note_pin(2'h0, 24'h0);
		set_on(8'h18);
		note_pin(2'h2, 24'h7);
		bus(1'b1, 6'h00, 32'h9);
		wt(40);
		note_pin(2'h2, 24'h18);
		bus(1'b1, 6'h00, 32'h1);
		wt(40);
		note_pin(2'h2, 24'h7);
		final_report;
	end

	// Whole run is under two thousand cycles; a hang ends here
	initial begin
		wt(20000);
		n_fail++;
		final_report;
	end
endmodule // sdc_contact_io_tb_top
`default_nettype wire
